//--- src/hcsp_pkg.sv
// Constants for the Hall-commutated single-PWM gate logic.
// Assumes one 200 MHz clock and a simple strobe register port.
//
// How it works
// - Scheme field 011 enables Hall commutation
// - Modulated high sides copy the single PWM input
// - Dead time from rising and sensor values
// - Active freewheel drives inverted PWM low
// - Diode freewheel keeps inverted-PWM gates low
// - Dir high: codes 101,100,110 table
// - Dir high: codes 010,011,001 table
// - Dir low: codes 101,100,110 table
// - Dir low: codes 010,011,001 table
// - Unused phase has both gates low
// - Codes 111 and 000 force gates low
// - Brake low overrides Hall and direction
// - Brake pattern: low, high, alternate, off
package hcsp_pkg;
	// Register port
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  REG_CTRL     = 8'h00;  // Scheme, freewheel, brake pattern
	localparam logic [7:0]  REG_DEAD     = 8'h04;  // Dead-time counts
	localparam logic [7:0]  REG_STAT     = 8'h08;  // Live inputs and gates
	// Control register fields
	localparam int          CTRL_SCH_LSB = 0;
	localparam int          CTRL_FW_BIT  = 3;
	localparam int          CTRL_BRK_LSB = 4;
	localparam logic [2:0]  SCHEME_HALL  = 3'h3;   // Hall-commutated single PWM
	localparam logic [2:0]  SCHEME_RST   = 3'h0;
	// Brake pattern codes
	localparam logic [1:0]  BRK_LOW      = 2'h0;
	localparam logic [1:0]  BRK_HIGH     = 2'h1;
	localparam logic [1:0]  BRK_ALT      = 2'h2;
	localparam logic [1:0]  BRK_OFF      = 2'h3;
	// Dead-time register fields and reset values
	localparam int          DEAD_RISE_LSB = 0;
	localparam int          DEAD_HALL_LSB = 8;
	localparam logic [7:0]  RISING_DEAD_TIME_RST   = 8'h0A;
	localparam logic [7:0]  SENSOR_MODE_DEAD_TIME_RST   = 8'h0A;
	// Status register fields
	localparam int          STAT_BAD_BIT  = 5;
	localparam int          STAT_GATE_LSB = 6;
	// Phase indices; gate vector is {lc,hc,lb,hb,la,ha}
	localparam logic [1:0]  PH_A         = 2'h0;
	localparam logic [1:0]  PH_B         = 2'h1;
	localparam logic [1:0]  PH_C         = 2'h2;
	localparam logic [1:0]  PH_NONE      = 2'h3;
	localparam logic [5:0]  ALL_LOW_SIDE = 6'h2A;
	localparam logic [5:0]  ALL_HIGH_SIDE = 6'h15;
	// Timing
	localparam int          CLK_PERIOD_NS = 5;
	localparam int          BRK_ALT_NS    = 10000;  // Half period of alternating brake
	localparam int          BRK_ALT_CYC   = BRK_ALT_NS / CLK_PERIOD_NS;
endpackage

//--- src/hcsp_top.sv
// Hall-commutated single-PWM gate logic for a three-phase bridge.
// Assumes pins come from outside the clock domain and the register
// master runs on clk_sys_i with one-cycle strobes.
`timescale 1ns/1ps

module hcsp_top
	import hcsp_pkg::*;
#(
	parameter int DT_W    = 8,            // Dead-time counter width
	parameter int ALT_CYC = BRK_ALT_CYC   // Cycles per alternating brake half
)(
	// Clock, reset, enable
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	input  wire logic              en_i,
	// Register port
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	// Controller and sensor pins
	input  wire logic              single_pwm_in_i,
	input  wire logic              rotation_direction_in_i,
	input  wire logic              rotor_sensor_1_i,
	input  wire logic              rotor_sensor_2_i,
	input  wire logic              rotor_sensor_3_i,
	input  wire logic              brake_request_n_i,
	// Gate outputs
	output logic                   gate_high_a_o,
	output logic                   gate_low_a_o,
	output logic                   gate_high_b_o,
	output logic                   gate_low_b_o,
	output logic                   gate_high_c_o,
	output logic                   gate_low_c_o
);

	localparam int ALT_W = $clog2(ALT_CYC + 1);
	localparam logic [ALT_W-1:0] ALT_LAST = ALT_W'(ALT_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// State
	////////////////////////////////////////////////////////////////////////////

	// Whole module state; pin bits are {brk_n,s3,s2,s1,dir,pwm}
	typedef struct packed {
		logic [5:0]             s1;      // First sync stage
		logic [5:0]             s2;      // Second sync stage
		logic [2:0]             scheme;  // Drive scheme select
		logic                   fw;      // freewheel_select: 1 active
		logic [1:0]             bsel;    // Brake pattern
		logic [DT_W-1:0]        dtr;     // rising_dead_time
		logic [DT_W-1:0]        dth;     // sensor_mode_dead_time
		logic [DT_W-1:0]        hcnt;    // Commutation blanking count
		logic [4:0]             key;     // Last {brake,dir,hall}
		logic [ALT_W-1:0]       acnt;    // Alternating brake timer
		logic                   aph;     // Alternating brake phase
		logic [5:0][DT_W-1:0]   gcnt;    // Per-gate turn-on delay
		logic [5:0]             gate;    // Gate drive flops
		logic [DATA_W-1:0]      rdata;   // Read data
	} hcsp_state_t;

	hcsp_state_t q;                      // Registered state
	hcsp_state_t d;                      // Next state

	// Decode results, also watched by the checks
	logic [2:0]  hall;                   // Hall code, sensor 1 is MSB
	logic        dir;                    // Synced direction
	logic        brk;                    // Brake requested
	logic        pwm;                    // Synced PWM
	logic        valid;                  // Hall code is legal
	logic        run;                    // Hall scheme selected
	logic [1:0]  mod_ph;                 // Modulated phase
	logic [1:0]  low_ph;                 // Phase with low side held on
	logic [5:0]  allow;                  // Gates the table may turn on
	logic [5:0]  flt;                    // Gates of the floating phase
	logic [5:0]  tgt;                    // Wanted gate levels
	logic        blank;                  // Commutation dead time active
	logic [4:0]  key;                    // Current {brake,dir,hall}

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	////////////////////////////////////////////////////////////////////////////

	// All behaviour in one process; en_i low freezes everything
	always_comb begin
		d      = q;
		hall   = {q.s2[2], q.s2[3], q.s2[4]};  // Only second stage is read
		dir    = q.s2[1];
		brk    = ~q.s2[5];
		pwm    = q.s2[0];
		run    = (q.scheme == SCHEME_HALL);
		valid  = 1'b1;
		mod_ph = PH_NONE;
		low_ph = PH_NONE;
		allow  = '0;
		flt    = '0;
		tgt    = '0;
		key    = {brk, dir, hall};

		// Commutation table for direction high
		case (hall)
			3'h5: begin
				mod_ph = PH_A;
				low_ph = PH_C;
			end
			3'h4: begin
				mod_ph = PH_B;
				low_ph = PH_C;
			end
			3'h6: begin
				mod_ph = PH_B;
				low_ph = PH_A;
			end
			3'h2: begin
				mod_ph = PH_C;
				low_ph = PH_A;
			end
			3'h3: begin
				mod_ph = PH_C;
				low_ph = PH_B;
			end
			3'h1: begin
				mod_ph = PH_A;
				low_ph = PH_B;
			end
			default: begin
				valid = 1'b0;                  // 111 and 000 are forbidden
			end
		endcase

		// Direction low swaps the two active phases of every entry
		if (!dir) begin
			{mod_ph, low_ph} = {low_ph, mod_ph};
		end

		// Build wanted gates; the third phase stays off
		for (int p = 0; p < 3; p++) begin
			if (mod_ph == 2'(p)) begin
				tgt[2*p]     = pwm;                // High side follows PWM
				tgt[2*p+1]   = ~pwm & q.fw;        // Inverted PWM or held low
				allow[2*p]   = 1'b1;
				allow[2*p+1] = q.fw;
			end else if (low_ph == 2'(p)) begin
				tgt[2*p+1]   = 1'b1;
				allow[2*p+1] = 1'b1;
			end else if (valid) begin
				flt[2*p+1 -: 2] = 2'h3;
			end
		end

		// Forbidden code drives every gate low
		if (!valid) begin
			tgt = '0;
		end

		// Brake ignores Hall and direction
		if (brk) begin
			case (q.bsel)
				BRK_LOW:  tgt = ALL_LOW_SIDE;
				BRK_HIGH: tgt = ALL_HIGH_SIDE;
				BRK_ALT:  tgt = q.aph ? ALL_HIGH_SIDE : ALL_LOW_SIDE;
				default:  tgt = '0;                // Bridge off, switch nodes float
			endcase
		end

		// Other schemes are not handled here, so the bridge stays off
		if (!run) begin
			tgt = '0;
		end

		// While the sensor dead time is nonzero, any change of pattern blanks all gates for it plus one cycle
		blank = q.hcnt != '0 || (key != q.key && q.dth != '0);
		if (blank) begin
			tgt = '0;
		end

		if (en_i) begin
			// Two-stage pin synchronisers
			d.s1 = {brake_request_n_i, rotor_sensor_3_i, rotor_sensor_2_i,
				rotor_sensor_1_i, rotation_direction_in_i, single_pwm_in_i};
			d.s2 = q.s1;

			// Register writes
			if (wr_i) begin
				case (addr_i)
					REG_CTRL: begin
						d.scheme = wdata_i[CTRL_SCH_LSB +: 3];
						d.fw     = wdata_i[CTRL_FW_BIT];
						d.bsel   = wdata_i[CTRL_BRK_LSB +: 2];
					end
					REG_DEAD: begin
						d.dtr = wdata_i[DEAD_RISE_LSB +: DT_W];
						d.dth = wdata_i[DEAD_HALL_LSB +: DT_W];
					end
					default: begin
						// Unmapped or read-only: write ignored
					end
				endcase
			end

			// Register reads, data valid the next cycle only
			d.rdata = '0;
			if (rd_i) begin
				case (addr_i)
					REG_CTRL: begin
						d.rdata[CTRL_SCH_LSB +: 3] = q.scheme;
						d.rdata[CTRL_FW_BIT]       = q.fw;
						d.rdata[CTRL_BRK_LSB +: 2] = q.bsel;
					end
					REG_DEAD: begin
						d.rdata[DEAD_RISE_LSB +: DT_W] = q.dtr;
						d.rdata[DEAD_HALL_LSB +: DT_W] = q.dth;
					end
					REG_STAT: begin
						d.rdata[4:0]                = key;
						d.rdata[STAT_BAD_BIT]       = ~valid;
						d.rdata[STAT_GATE_LSB +: 6] = q.gate;
					end
					default: begin
						// Unmapped reads return zero
					end
				endcase
			end

			// Commutation blanking counter
			if (key != q.key) begin
				d.key  = key;
				d.hcnt = q.dth;
			end else if (q.hcnt != '0) begin
				d.hcnt = q.hcnt - 1'b1;
			end

			// Alternating brake timer runs only while that pattern is in use
			if (brk && q.bsel == BRK_ALT) begin
				if (q.acnt == ALT_LAST) begin
					d.acnt = '0;
					d.aph  = ~q.aph;
				end else begin
					d.acnt = q.acnt + 1'b1;
				end
			end else begin
				d.acnt = '0;
				d.aph  = 1'b0;
			end

			// Per-gate dead time: off at once, on only after the partner
			// has been off for the rising dead time
			for (int i = 0; i < 6; i++) begin
				if (!tgt[i]) begin
					d.gate[i] = 1'b0;
					d.gcnt[i] = '0;
				end else if (!q.gate[i]) begin
					if (q.gate[i ^ 1]) begin
						d.gcnt[i] = '0;            // Partner still conducting
					end else if (q.gcnt[i] >= q.dtr) begin
						d.gate[i] = 1'b1;
					end else begin
						d.gcnt[i] = q.gcnt[i] + 1'b1;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	////////////////////////////////////////////////////////////////////////////

	// Synchronous reset; bridge off and Hall scheme not selected
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			q        <= '0;
			q.scheme <= SCHEME_RST;
			q.dtr    <= DT_W'(RISING_DEAD_TIME_RST);
			q.dth    <= DT_W'(SENSOR_MODE_DEAD_TIME_RST);
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign rdata_o       = q.rdata;
	assign gate_high_a_o = q.gate[0];
	assign gate_low_a_o  = q.gate[1];
	assign gate_high_b_o = q.gate[2];
	assign gate_low_b_o  = q.gate[3];
	assign gate_high_c_o = q.gate[4];
	assign gate_low_c_o  = q.gate[5];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	// Without the Hall scheme the bridge is off
	scheme_off_a: assert property (en_i && !run |=> q.gate == '0)
		else $error("gate on outside Hall scheme");

	// No high side turns on while the PWM is low
	// Brake patterns may hold high sides on, so only the table case is watched
	pwm_follow_a: assert property (en_i && !pwm && !brk
		|=> (q.gate & ALL_HIGH_SIDE) == '0)
		else $error("high side on with PWM low");

	// Both switches of a phase never conduct together
	no_overlap_a: assert property (
		!(q.gate[0] && q.gate[1]) && !(q.gate[2] && q.gate[3]) && !(q.gate[4] && q.gate[5]))
		else $error("shoot-through on a phase");

	// A gate rises only after its partner was off a full dead time
	dead_gap_a: assert property ($rose(q.gate[0]) |-> !$past(q.gate[1])
		&& $past(q.gcnt[0]) >= $past(q.dtr))
		else $error("high side A rose without dead time");

	// Inverted PWM reaches the modulated low side in active freewheel
	active_fw_a: assert property (
		en_i && run && !brk && !blank && valid && q.fw && pwm && mod_ph == PH_A
		&& q.dtr == '0 ##1 en_i && run && !brk && !pwm && mod_ph == PH_A && q.dtr == '0
		&& !blank ##1 en_i && run && !brk && valid && q.fw && !pwm && mod_ph == PH_A
		&& q.dtr == '0 && !blank |=> q.gate[1])
		else $error("active freewheel did not drive low side A");

	// Diode freewheel never turns on the modulated low side
	diode_fw_a: assert property ($rose(q.gate[1]) && !$past(q.fw) && !$past(brk)
		|-> $past(mod_ph) != PH_A)
		else $error("modulated low side on in diode freewheel");

	// Only table gates may be on for a legal code
	table_a: assert property (en_i && run && valid && !brk
		|=> (q.gate & ~$past(allow)) == '0)
		else $error("gate outside commutation table");

	// The floating phase keeps both gates low
	float_a: assert property (en_i && run && valid && !brk
		|=> (q.gate & $past(flt)) == '0)
		else $error("floating phase driven");

	// Forbidden codes turn every gate off
	forbidden_a: assert property (en_i && !valid && !brk |=> q.gate == '0)
		else $error("gate on with forbidden Hall code");

	// Brake low-side pattern keeps high sides off
	brake_low_a: assert property (en_i && brk && q.bsel == BRK_LOW
		|=> (q.gate & ALL_HIGH_SIDE) == '0)
		else $error("high side on during low-side brake");

	// Brake off pattern releases the bridge
	brake_off_a: assert property (en_i && brk && q.bsel == BRK_OFF |=> q.gate == '0)
		else $error("gate on during off brake");

	// Main scenarios
	commutate_c: cover property (en_i && run && valid && !brk ##1 q.gate[0]);
	forbid_c:    cover property (en_i && run && !valid && !brk);
	alt_brake_c: cover property (brk && q.bsel == BRK_ALT && $rose(q.aph));
	dir_low_c:   cover property (en_i && run && valid && !dir && q.gate[5]);

endmodule // hcsp_top

//--- bench/hcsp_ctrl_model.sv
// Model of the simple controller: a clock-like PWM and a direction level.
// Assumes the bench clock drives it; the device does its own pin sync.
`timescale 1ns/1ps

module hcsp_ctrl_model (
	// Clock and control from the bench
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic       level_i,
	input  wire logic       dir_i,
	input  wire logic [7:0] high_cyc_i,
	input  wire logic [7:0] low_cyc_i,
	// Pins towards the device
	output logic            pwm_o,
	output logic            dir_o
);
	logic [7:0] cnt_q;  // Cycles spent in the current PWM half

	////////////////////////////////////////////////////////////////////////////
	// PWM from fixed high and low counts; stopped it holds a steady level
	always @(posedge clk_i) begin
		if (!run_i) begin
			pwm_o <= level_i;  // Steady level lets the bench freeze a state
			cnt_q <= 8'h00;
		end else if (cnt_q >= (pwm_o ? high_cyc_i : low_cyc_i) - 8'h01) begin
			pwm_o <= ~pwm_o;  // Clock-like toggling
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
		dir_o <= dir_i;  // Direction is a plain steady level
	end
endmodule  // hcsp_ctrl_model

//--- bench/hall_commutated_single_pwm_test.sv
// Self-checking bench for the Hall-commutated single-PWM gate logic.
// Assumes hcsp_top with a short alternating-brake half period of 8 cycles.
`timescale 1ns/1ps

module hall_commutated_single_pwm_test;
	import hcsp_pkg::*;
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

	// Clock, reset and register port
	logic              clk_sys;
	logic              nrst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr_s;
	logic              rd_s;
	logic [DATA_W-1:0] rdata;
	// Pins and controller model controls
	logic [2:0]        hall;
	logic              brk_n;
	logic              run;
	logic              lvl;
	logic              dir;
	logic [7:0]        hi_cyc;
	logic [7:0]        lo_cyc;
	logic              pwm_w;
	logic              dir_w;
	logic [5:0]        gates;  // {lc,hc,lb,hb,la,ha}
	int                fails;
	int                cmp_count;

	////////////////////////////////////////////////////////////////////////////
	// Device and controller model
	hcsp_top #(.DT_W(8), .ALT_CYC(8)) i_dut (
		.clk_sys_i(clk_sys), .nrst_i(nrst), .en_i(1'b1),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
		.single_pwm_in_i(pwm_w), .rotation_direction_in_i(dir_w),
		.rotor_sensor_1_i(hall[2]), .rotor_sensor_2_i(hall[1]), .rotor_sensor_3_i(hall[0]),
		.brake_request_n_i(brk_n),
		.gate_high_a_o(gates[0]), .gate_low_a_o(gates[1]), .gate_high_b_o(gates[2]),
		.gate_low_b_o(gates[3]), .gate_high_c_o(gates[4]), .gate_low_c_o(gates[5]));
	hcsp_ctrl_model i_ctrl (
		.clk_i(clk_sys), .run_i(run), .level_i(lvl), .dir_i(dir),
		.high_cyc_i(hi_cyc), .low_cyc_i(lo_cyc), .pwm_o(pwm_w), .dir_o(dir_w));

	////////////////////////////////////////////////////////////////////////////
	// Helpers: all bench activity sits 1 ns after the rising edge
	task automatic samp();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		samp();
		wr_s  <= 1'b0;
		samp();  // Idle edge so a following call never reassigns the strobe
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd_s <= 1'b1;
		samp();
		rd_s <= 1'b0;
		d = rdata;  // Data stand only in the cycle after the strobe
		samp();     // Idle edge so a following call never reassigns the strobe
	endtask
	// Pin change reaches gates after sync, blanking and turn-on delay
	task automatic settle();
		repeat (12) samp();
	endtask
	// Expected gates from the commutation tables; {mod,low} as phase indices
	function automatic logic [5:0] expg(input logic d, input logic [2:0] h,
		input logic p, input logic fw);
		logic [3:0] ml;
		logic [5:0] g;
		g = 6'h00;
		case ({d, h})
			4'hD: ml = 4'h2; 4'hC: ml = 4'h6; 4'hE: ml = 4'h4;  // Dir high, first half
			4'hA: ml = 4'h8; 4'hB: ml = 4'h9; 4'h9: ml = 4'h1;  // Dir high, second half
			4'h5: ml = 4'h8; 4'h4: ml = 4'h9; 4'h6: ml = 4'h1;  // Dir low, first half
			4'h2: ml = 4'h2; 4'h3: ml = 4'h6; 4'h1: ml = 4'h4;  // Dir low, second half
			default: return 6'h00;                               // Forbidden codes
		endcase
		g[2 * ml[1:0] + 1] = 1'b1;
		g[2 * ml[3:2]]     = p;
		g[2 * ml[3:2] + 1] = fw & ~p;
		return g;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		logic [31:0] d;
		rd(REG_CTRL, d);
		`CHK("ctrl reset", 32'h0000_0000, d)
		rd(REG_DEAD, d);
		`CHK("dead reset", 32'h0000_0A0A, d)
		rd(8'h0C, d);
		`CHK("unmapped", 32'h0000_0000, d)
		hall <= 3'h5;
		settle();
		`CHK("scheme off", 6'h00, gates)
		wr(REG_DEAD, 32'h0000_0000);
		rd(REG_DEAD, d);
		`CHK("dead rw", 32'h0000_0000, d)
	endtask
	// Every code, both directions, both freewheel kinds, PWM high and low
	task automatic t_table();
		for (int f = 1; f >= 0; f--) begin
			wr(REG_CTRL, 32'h3 | (f << 3));
			for (int k = 0; k < 32; k++) begin
				dir  <= k[4];
				hall <= k[3:1];
				lvl  <= k[0];
				settle();
				`CHK("gates", expg(k[4], k[3:1], k[0], f[0]), gates)
			end
		end
	endtask
	// Wrong scheme drives nothing even with a legal code
	task automatic t_scheme();
		wr(REG_CTRL, 32'h0000_000A);
		hall <= 3'h5;
		settle();
		`CHK("scheme 010", 6'h00, gates)
	endtask
	// Brake patterns over a forbidden code, off over a legal one; alternate must flip
	task automatic t_brake();
		logic [5:0] ex [4] = '{ALL_LOW_SIDE, ALL_HIGH_SIDE, ALL_LOW_SIDE, 6'h00};
		logic [31:0] d;
		int n;
		for (int p = 0; p < 4; p++) begin
			hall <= (p == 3) ? 3'h5 : 3'h7;  // Legal code would drive gates if off failed
			wr(REG_CTRL, 32'hB | (p << 4));
			brk_n <= 1'b0;
			settle();
			if (p == 0) begin
				rd(REG_STAT, d);
				`CHK("status", {20'h0, ALL_LOW_SIDE, 1'b1, 5'h1F}, d)
			end
			if (p == 2) begin
				n = 0;
				while (gates !== ALL_LOW_SIDE && n < 40) begin samp(); n++; end
				`CHK("alt low", ALL_LOW_SIDE, gates)
				n = 0;
				while (gates !== ALL_HIGH_SIDE && n < 40) begin samp(); n++; end
			end
			`CHK("brake", (p == 2) ? ALL_HIGH_SIDE : ex[p], gates)
			brk_n <= 1'b1;
			settle();
		end
	endtask
	// Pulse width shrinks by the rising dead time plus one cycle; period kept
	task automatic t_dead();
		int h;
		int l;
		int ov;
		wr(REG_CTRL, 32'h0000_000B);
		wr(REG_DEAD, 32'h0000_0003);
		dir  <= 1'b1;
		hall <= 3'h5;
		settle();
		run <= 1'b1;
		h = 0;
		l = 0;
		ov = 0;
		// Gate is already on from the steady level: wait for a full pulse
		while (gates[0] !== 1'b0 && l < 100) begin samp(); l++; end
		while (gates[0] !== 1'b1 && l < 100) begin samp(); l++; end
		l = 0;
		while (gates[0] === 1'b1 && h < 100) begin ov += gates[1]; samp(); h++; end
		while (gates[0] === 1'b0 && l < 100) begin ov += gates[1] & gates[0]; samp(); l++; end
		`CHK("pulse", 8, h)
		`CHK("period", 20, h + l)
		`CHK("overlap", 0, ov)
		run <= 1'b0;
	endtask
	// Commutation change blanks every gate for the sensor dead time plus one cycle
	task automatic t_blank();
		int n;
		lvl <= 1'b1;
		wr(REG_DEAD, 32'h0000_0500);
		run <= 1'b1;  // Running PWM also exercises active freewheel with no rising delay
		settle();
		hall <= 3'h4;
		n = 0;
		repeat (20) begin samp(); n += (gates === 6'h00); end
		`CHK("blanking", 6, n)
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Verdict, clock, watchdog and main sequence
	task automatic print_verdict();
		if (fails == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Whole run needs some 1000 cycles; 20000 means a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		print_verdict();
	end
	initial begin
		{nrst, wr_s, rd_s, run, lvl, hall} = '0;
		{addr, wdata, hi_cyc, lo_cyc} = {8'h00, 32'h0, 8'd12, 8'd8};
		{brk_n, dir, fails, cmp_count} = {2'b11, 64'h0};
		repeat (16) @(posedge clk_sys);
		#1;
		nrst <= 1'b1;
		t_regs();
		t_table();
		t_scheme();
		t_brake();
		t_dead();
		t_blank();
		print_verdict();
	end
endmodule  // hall_commutated_single_pwm_test
